/* File: emadc_top.sv */
// external memory area decoder and bus clock divider
// chip selects and both divided clocks leave straight from flip-flops
// assumes a plain register port synchronous to clk_in; accesses are
// presented on access_addr_in / access_valid_in by the memory controller
//
// Contract
// - four area select registers place the four chip-select areas.
// - all areas together form one 256 MB external window.
// - areas live only in 1000_0000h to 1fff_ffffh; decode only there.
// - hit when address[31:24] and mask[7:0] equals base[31:24].
// - divider makes internal bus clock and bus clock pin, ratio two to six.
// - code 000..100 selects divide by 2, 3, 4, 5, 6.
// - divide by 3 is high 1 low 2, by 5 high 2 low 3.
// - divider register reads 0000_0004h after reset, dividing by six.
// - divider bits 31:4 read zero; software writes zero.
`timescale 1ns/100ps
`default_nettype none
module emadc_top
  import emadc_pkg::*;
(
  input wire logic clk_in, // 20 MHz system clock
  input wire logic resetn_in, // async reset, active low
  input wire logic [31:0] reg_addr_in, // register byte address
  input wire logic [31:0] reg_wdata_in, // register write data
  input wire logic reg_wr_in, // write strobe
  input wire logic reg_rd_in, // read strobe
  output logic [31:0] reg_rdata_out, // read data, cycle after strobe
  input wire logic [31:0] access_addr_in, // external access address
  input wire logic access_valid_in, // access presented this cycle
  output logic [3:0] chip_select_area_n_out, // chip selects, active low
  output logic window_hit_out, // access fell in a programmed area
  output logic int_bus_clk_out, // divided internal bus clock
  output logic external_bus_clock_pin_out, // divided bus clock pin
  output logic [2:0] div_active_out // ratio code now in use
);

  typedef struct packed {
    // area select registers
    logic [3:0][7:0] base;
    logic [3:0][7:0] mask;
    // divider register and the ratio now running
    logic [3:0] divider_code;
    logic [2:0] active_code;
    // clock generator
    logic [2:0] cnt;
    logic clk_lvl;
    logic int_clk_lvl;
    // registered decode results
    logic [3:0] cs_n;
    logic hit;
    // register port read data
    logic [31:0] rdata;
  } emadc_state_type;

  emadc_state_type s_q;
  emadc_state_type s_d;
  logic [3:0] match;
  logic in_window;
  logic [2:0] period_last;
  logic [2:0] high_len;
  logic [3:0][7:0] masked_top; // top address byte through each mask
  logic [3:0][31:0] area_word; // read view of each area register
  logic period_wrap; // counter at the last count of its period
  logic code_legal; // stored code is one of the five ratios

  // only addresses inside the 256 MB window are ever decoded
  // top nibble 1 is the whole window, so no area can reach outside it
  assign in_window = (access_addr_in[31:28] == emadc_window_top);

  // one masked compare per area; the window test keeps addresses
  // outside 1000_0000h..1fff_ffffh from ever selecting
  genvar gi;
  generate
    for (gi = 0; gi < emadc_areas; gi++)
    begin : g_area
      // top address byte seen through this area's size mask
      assign masked_top[gi] = access_addr_in[31:24] & s_q.mask[gi];
      assign match[gi] = access_valid_in && in_window &&
        (masked_top[gi] == s_q.base[gi]);
    end
  endgenerate

  // read view per area; bits 23:8 are not stored and read as zero
  generate
    for (gi = 0; gi < emadc_areas; gi++)
    begin : g_word
      assign area_word[gi] = {s_q.base[gi], 16'h0000, s_q.mask[gi]};
    end
  endgenerate

  // period end and code check shared by the divider logic
  assign period_wrap = (s_q.cnt >= period_last);
  // forbidden codes are kept for read back but never run
  assign code_legal = (s_q.divider_code <= emadc_div_code_max);

  // period length and high phase for the active code
  // a table rather than arithmetic keeps the odd ratios exact
  always_comb
  begin
    period_last = 3'h1;
    high_len = 3'h1;
    unique case (s_q.active_code)
      // divide by 2, high 1 low 1
      3'h0:
      begin
        period_last = 3'h1;
        high_len = 3'h1;
      end
      // divide by 3, high 1 low 2
      3'h1:
      begin
        period_last = 3'h2;
        high_len = 3'h1;
      end
      // divide by 4, high 2 low 2
      3'h2:
      begin
        period_last = 3'h3;
        high_len = 3'h2;
      end
      // divide by 5, high 2 low 3
      3'h3:
      begin
        period_last = 3'h4;
        high_len = 3'h2;
      end
      // divide by 6, high 3 low 3
      3'h4:
      begin
        period_last = 3'h5;
        high_len = 3'h3;
      end
      // codes above 4 never become active; kept for a total table
      default:
      begin
        period_last = 3'h5;
        high_len = 3'h3;
      end
    endcase
  end

  // next state: register writes, decode, divider, read data
  // one process computes every next value; the flops below only copy it
  always_comb
  begin
    s_d = s_q;
    // register writes; the window must be idle meanwhile
    if (reg_wr_in)
    begin
      unique case (reg_addr_in)
        // each area keeps base and mask; bits 23:8 are dropped
        emadc_area_sel_0_addr:
        begin
          s_d.base[0] = reg_wdata_in[emadc_base_lsb +: 8];
          s_d.mask[0] = reg_wdata_in[emadc_mask_lsb +: 8];
        end
        // area 1 select
        emadc_area_sel_1_addr:
        begin
          s_d.base[1] = reg_wdata_in[emadc_base_lsb +: 8];
          s_d.mask[1] = reg_wdata_in[emadc_mask_lsb +: 8];
        end
        // area 2 select
        emadc_area_sel_2_addr:
        begin
          s_d.base[2] = reg_wdata_in[emadc_base_lsb +: 8];
          s_d.mask[2] = reg_wdata_in[emadc_mask_lsb +: 8];
        end
        // area 3 select
        emadc_area_sel_3_addr:
        begin
          s_d.base[3] = reg_wdata_in[emadc_base_lsb +: 8];
          s_d.mask[3] = reg_wdata_in[emadc_mask_lsb +: 8];
        end
        // all four code bits stored, forbidden ones too
        emadc_clk_div_addr:
        begin
          s_d.divider_code = reg_wdata_in[3:0];
        end
        default:
        begin
          s_d.divider_code = s_q.divider_code; // unmapped write ignored
        end
      endcase
    end

    // read data stands one cycle after the strobe, zero otherwise
    // a write and a read never share a cycle, so the blocks are independent
    s_d.rdata = 32'h0000_0000;
    if (reg_rd_in)
    begin
      unique case (reg_addr_in)
        emadc_area_sel_0_addr:
        begin
          s_d.rdata = area_word[0];
        end
        emadc_area_sel_1_addr:
        begin
          s_d.rdata = area_word[1];
        end
        emadc_area_sel_2_addr:
        begin
          s_d.rdata = area_word[2];
        end
        emadc_area_sel_3_addr:
        begin
          s_d.rdata = area_word[3];
        end
        emadc_clk_div_addr:
        begin
          // reserved bits 31:4 always read zero
          s_d.rdata = {28'h000_0000, s_q.divider_code};
        end
        default:
        begin
          // unmapped addresses read zero
          s_d.rdata = 32'h0000_0000;
        end
      endcase
    end

    // chip selects follow the decode one cycle later; no match, none low
    // overlapping areas would pull several selects; software avoids that
    s_d.cs_n = ~match;
    s_d.hit = |match;

    // divider: count through one period, high for the first high_len counts
    if (period_wrap)
    begin
      s_d.cnt = emadc_cnt_rst;
      // new ratio taken only at a period boundary so no runt pulse appears
      // forbidden codes are not taken up; the old ratio keeps running
      if (code_legal)
      begin
        s_d.active_code = s_q.divider_code[2:0];
      end
    end
    else
    begin
      s_d.cnt = s_q.cnt + 3'h1;
    end

    // level for the next count; count 0 starts the high phase, so a new
    // ratio always begins with a full high phase and never a short one
    if (s_d.cnt == emadc_cnt_rst)
    begin
      s_d.clk_lvl = 1'b1;
    end
    else
    begin
      s_d.clk_lvl = s_d.cnt < high_len;
    end
    // both clocks come from one level, so they can never drift apart
    s_d.int_clk_lvl = s_d.clk_lvl;
  end

  // single state register, reset to documented values
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      // area 0 covers the whole window, the others match nothing
      s_q.base <= {emadc_areax_base_rst, emadc_areax_base_rst,
                   emadc_areax_base_rst, emadc_area0_base_rst};
      s_q.mask <= {emadc_areax_mask_rst, emadc_areax_mask_rst,
                   emadc_areax_mask_rst, emadc_area0_mask_rst};
      // divide by six from reset
      s_q.divider_code <= emadc_div_rst;
      s_q.active_code <= emadc_div_rst[2:0];
      // both clocks start at the top of a high phase
      s_q.cnt <= emadc_cnt_rst;
      s_q.clk_lvl <= 1'b1;
      s_q.int_clk_lvl <= 1'b1;
      // no select and no read data while reset holds
      s_q.cs_n <= 4'hf;
      s_q.hit <= 1'b0;
      s_q.rdata <= 32'h0000_0000;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // all outputs straight from the state register
  // register port
  assign reg_rdata_out = s_q.rdata;

  // decode results
  assign chip_select_area_n_out = s_q.cs_n;
  assign window_hit_out = s_q.hit;

  // divided clocks and the ratio now running
  assign int_bus_clk_out = s_q.int_clk_lvl;
  assign external_bus_clock_pin_out = s_q.clk_lvl;
  assign div_active_out = s_q.active_code;

endmodule
`default_nettype wire

/* File: emadc_pkg.sv */
// constants for the external memory area decoder and bus clock divider
// assumes a 32-bit register port with word offsets and one system clock
package emadc_pkg;
  localparam int unsigned emadc_areas = 4;
  // register byte addresses
  localparam logic [31:0] emadc_area_sel_0_addr = 32'h4001_0110;
  localparam logic [31:0] emadc_area_sel_1_addr = 32'h4001_0114;
  localparam logic [31:0] emadc_area_sel_2_addr = 32'h4001_0118;
  localparam logic [31:0] emadc_area_sel_3_addr = 32'h4001_011c;
  localparam logic [31:0] emadc_clk_div_addr = 32'h4001_0120;
  // area select field layout: base in [31:24], size mask in [7:0]
  localparam int unsigned emadc_base_lsb = 24;
  localparam int unsigned emadc_mask_lsb = 0;
  // reset: area 0 spans the whole window, others never match
  localparam logic [7:0] emadc_area0_base_rst = 8'h10;
  localparam logic [7:0] emadc_area0_mask_rst = 8'hf0;
  localparam logic [7:0] emadc_areax_base_rst = 8'hff;
  localparam logic [7:0] emadc_areax_mask_rst = 8'h00;
  // external window 1000_0000h..1fff_ffffh, 256 MB
  localparam logic [3:0] emadc_window_top = 4'h1;
  // divider codes and reset value
  localparam logic [3:0] emadc_div_rst = 4'h4;
  localparam logic [3:0] emadc_div_code_max = 4'h4;
  localparam logic [2:0] emadc_cnt_rst = 3'h0;
endpackage

/* File: emadc_assertions.sv */
// port checker for the area decoder and bus clock divider
// sees only the top ports; bound into emadc_top below
`timescale 1ns/100ps
`default_nettype none
module emadc_assertions import emadc_pkg::*; (
  input wire logic clk_in, resetn_in, reg_wr_in, reg_rd_in, access_valid_in, window_hit_out,
  input wire logic int_bus_clk_out, external_bus_clock_pin_out,
  input wire logic [31:0] reg_addr_in, reg_wdata_in, reg_rdata_out, access_addr_in,
  input wire logic [3:0] chip_select_area_n_out,
  input wire logic [2:0] div_active_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  // shape checks start at a rising bus clock so a ratio change lands cleanly
  a_pin_same_clk: assert property (external_bus_clock_pin_out == int_bus_clk_out)
    else $error("pin clock differs");
  a_ratio_legal: assert property (div_active_out <= 3'h4) else $error("ratio code");
  a_rdata_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
    else $error("rdata idle");
  a_div_reserved: assert property (reg_rd_in && reg_addr_in == emadc_clk_div_addr
    |=> reg_rdata_out[31:4] == 28'h0) else $error("reserved bits");
  a_outside_miss: assert property (access_valid_in && access_addr_in[31:28] != 4'h1
    |=> chip_select_area_n_out == 4'hf && !window_hit_out) else $error("outside hit");
  a_idle_no_cs: assert property (!access_valid_in |=> chip_select_area_n_out == 4'hf)
    else $error("select when idle");
  a_hit_any_cs: assert property (window_hit_out == (chip_select_area_n_out != 4'hf))
    else $error("hit flag");
  a_div6_shape: assert property (div_active_out == 3'h4 && $rose(int_bus_clk_out)
    |-> int_bus_clk_out [*3] ##1 !int_bus_clk_out [*3]) else $error("div6 shape");
  a_div5_shape: assert property (div_active_out == 3'h3 && $rose(int_bus_clk_out)
    |-> int_bus_clk_out [*2] ##1 !int_bus_clk_out [*3]) else $error("div5 shape");
  a_div3_shape: assert property (div_active_out == 3'h1 && $rose(int_bus_clk_out)
    |-> int_bus_clk_out ##1 !int_bus_clk_out [*2]) else $error("div3 shape");
  a_change_wrap: assert property ($changed(div_active_out) |-> $rose(int_bus_clk_out))
    else $error("ratio switched mid period");
  c_div3: cover property (div_active_out == 3'h1);
  c_div5: cover property (div_active_out == 3'h3);
  c_hit: cover property (window_hit_out);
endmodule
bind emadc_top emadc_assertions u_chk (.*);
`default_nettype wire

/* File: emadc_mem_model.sv */
// far side memory stand-in: measures the pin clock high and low runs
// assumes the pin clock is registered on clk_in
`timescale 1ns/100ps
`default_nettype none
module emadc_mem_model (
  input wire logic clk_in, // system clock
  input wire logic bus_clk_in, // bus clock pin
  output logic [3:0] hi_len_out, // last high run, cycles
  output logic [3:0] lo_len_out // last low run, cycles
);
  logic prev;
  logic [3:0] run;
  // a run closes on each level change of the pin
  always_ff @(posedge clk_in)
  begin
    prev <= bus_clk_in;
    run <= (bus_clk_in == prev) ? run + 4'h1 : 4'h1;
    if (bus_clk_in != prev && prev)
      hi_len_out <= run;
    if (bus_clk_in != prev && !prev)
      lo_len_out <= run;
  end
endmodule
`default_nettype wire

/* File: test_ext_mem_area_decode_clkdiv.sv */
// bench: register port tasks, access probes, pin clock shape per ratio
// assumes emadc_top, its checker and the memory stand-in
`timescale 1ns/100ps
`default_nettype none
module test_ext_mem_area_decode_clkdiv import emadc_pkg::*; ;
  logic clk_in = 1'b0, resetn_in = 1'b0, wr = 1'b0, rd = 1'b0, av = 1'b0, hit, ibc, pin;
  logic [31:0] ra = 32'h0, wd = 32'h0, aa = 32'h0, rdata;
  logic [3:0] cs_n, hi, lo;
  logic [2:0] act;
  int err_count = 0, samples_checked = 0, cyc = 0;
  int hx[6] = '{1, 1, 2, 2, 3, 3};
  int lx[6] = '{1, 2, 2, 3, 3, 3};
  always #25 clk_in = ~clk_in;
  emadc_top dut (.clk_in(clk_in), .resetn_in(resetn_in), .reg_addr_in(ra), .reg_wdata_in(wd),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .access_addr_in(aa),
    .access_valid_in(av), .chip_select_area_n_out(cs_n), .window_hit_out(hit),
    .int_bus_clk_out(ibc), .external_bus_clock_pin_out(pin), .div_active_out(act));
  emadc_mem_model mem (.clk_in(clk_in), .bus_clk_in(pin), .hi_len_out(hi), .lo_len_out(lo));
  task chk(input string n, input logic [31:0] s, e);
    samples_checked++;
    if (s !== e)
    begin
      err_count++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task wreg(input logic [31:0] a, d);
    @(posedge clk_in);
    wr <= 1'b1;
    ra <= a;
    wd <= d;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask
  task rreg(input string n, input logic [31:0] a, e);
    @(posedge clk_in);
    rd <= 1'b1;
    ra <= a;
    @(posedge clk_in);
    rd <= 1'b0;
    #1 chk(n, rdata, e);
  endtask
  // selects show one cycle after the access edge
  task acc(input logic [31:0] a, input logic [3:0] e);
    @(posedge clk_in);
    av <= 1'b1;
    aa <= a;
    @(posedge clk_in);
    av <= 1'b0;
    #1 chk("cs", 32'(cs_n), 32'(e));
    chk("hit", 32'(hit), 32'(e != 4'hf));
  endtask
  // hang guard
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_count++;
      conclude();
    end
  end
  initial
  begin
    repeat (8) @(posedge clk_in);
    resetn_in <= 1'b1;
    rreg("div", emadc_clk_div_addr, 32'h4);
    rreg("area0", emadc_area_sel_0_addr, 32'h1000_00f0);
    rreg("hole", 32'h4001_0124, 32'h0);
    acc(32'h1fff_ffff, 4'he);
    // four quarter windows, registers rewritten while no access runs
    for (int i = 0; i < 4; i++)
      wreg(emadc_area_sel_0_addr + 32'(4 * i), 32'h1000_00fc + (32'(i) << 26));
    for (int i = 0; i < 4; i++)
      acc(32'h1012_3456 + (32'(i) << 26), ~(4'h1 << i));
    acc(32'h2000_0000, 4'hf);
    wreg(emadc_area_sel_3_addr, 32'hff00_0000);
    acc(32'h1c00_0000, 4'hf);
    // code 5 is forbidden: stored, old ratio kept
    for (int c = 0; c < 6; c++)
    begin
      wreg(emadc_clk_div_addr, 32'(c));
      repeat (24) @(posedge clk_in);
      rreg("div rd", emadc_clk_div_addr, 32'(c));
      chk("ratio", 32'(act), (c == 5) ? 32'h4 : 32'(c));
      chk("high", 32'(hi), hx[c]);
      chk("low", 32'(lo), lx[c]);
      chk("int clk", 32'(ibc), 32'(pin));
    end
    conclude();
  end
endmodule
`default_nettype wire
